// [rtl/uart_isr_pkg.sv]
// Notes on behaviour
// - DMA overflow indicator is overflow enable AND DMA overflow flag.
// - DMA timeout indicator is timeout enable AND DMA timeout flag.
// - DMA CTS-change indicator is modem enable AND DMA CTS flag.
// - DMA line status indicator is line enable AND DMA line flag.
// - DMA overflow flag sets when TX or RX overflow flag sets.
// - DMA overflow flag clears only once both overflow flags clear.
// - DMA timeout flag sets when RX holds data, idle, counter hits compare.
// - DMA timeout flag is read-only, cleared by buffer read while RX active.
// - DMA CTS flag sets when the CTS change flag becomes one.
// - DMA CTS flag clears when software writes one to CTS change flag.
// - DMA line flag sets when break, framing or parity flag is set.
// - In RS-485 mode an address byte also sets the DMA line flag.
// - DMA line flag clears only when break, framing, parity, address all clear.
// - LIN break indicator is LIN break enable AND LIN break flag.
// - Status register at 0x1C, resets to 0x0000_0002.
// - Non-DMA overflow indicator is overflow enable AND overflow flag.
// - RX overflow sets when a byte arrives into a full 64-byte FIFO.
package uart_isr_pkg;
   // ----------------------------------------------------------------
   // Register offsets
   // ----------------------------------------------------------------
   localparam logic [7:0] OFS_RECEIVE_BUF = 8'h00;
   localparam logic [7:0] OFS_ENABLE = 8'h04;
   localparam logic [7:0] OFS_MODEM = 8'h10;
   localparam logic [7:0] OFS_LINE = 8'h18;
   localparam logic [7:0] OFS_ISR = 8'h1c;
   localparam logic [7:0] OFS_TIMEOUT = 8'h20;
   localparam logic [7:0] OFS_CTRL = 8'h24;
   localparam logic [7:0] OFS_EVT_STATUS = 8'h28;
   localparam logic [7:0] OFS_EVT_MASK = 8'h2c;
   // ----------------------------------------------------------------
   // Field positions
   // ----------------------------------------------------------------
   localparam int EN_RDA = 0;
   localparam int EN_THRE = 1;
   localparam int EN_LINE = 2;
   localparam int EN_CTS = 3;
   localparam int EN_TOUT = 4;
   localparam int EN_OVF = 5;
   localparam int EN_LIN = 8;
   localparam int LN_RX_OVF = 0;
   localparam int LN_ADDR = 3;
   localparam int LN_PARITY = 4;
   localparam int LN_FRAME = 5;
   localparam int LN_BREAK = 6;
   localparam int LN_TX_OVF = 24;
   localparam int MD_CTS_CHG = 0;
   localparam int MD_CTS_LVL = 4;
   localparam int CT_DMA = 0;
   localparam int CT_RS485 = 1;
   localparam int CT_RX_EN = 2;
   localparam int IS_LIN_FLAG = 7;
   localparam int IS_DMA_IND = 26;
   localparam int IS_DMA_FLAG = 18;
   localparam int NUM_EVT = 5;
   // ----------------------------------------------------------------
   // Reset values and sizes
   // ----------------------------------------------------------------
   localparam logic [31:0] ISR_RESET = 32'h0000_0002;
   localparam logic [8:0] ENABLE_RESET = 9'h000;
   localparam logic [7:0] TOUT_CMP_RESET = 8'h00;
   localparam logic [2:0] CTRL_RESET = 3'h4;
   localparam logic [6:0] RX_FIFO_DEPTH = 7'h40;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// [rtl/uart_isr_dma_flags.sv]
// Design decision made here: the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
module uart_isr_dma_flags
   import uart_isr_pkg::*;
(
   input wire logic MCLK_I,
   input wire logic RST_N_I,
   // AXI4-Lite slave
   input wire logic [7:0] S_AXI_AWADDR_I,
   input wire logic S_AXI_AWVALID_I,
   output logic S_AXI_AWREADY_O,
   input wire logic [31:0] S_AXI_WDATA_I,
   input wire logic [3:0] S_AXI_WSTRB_I,
   input wire logic S_AXI_WVALID_I,
   output logic S_AXI_WREADY_O,
   output logic [1:0] S_AXI_BRESP_O,
   output logic S_AXI_BVALID_O,
   input wire logic S_AXI_BREADY_I,
   input wire logic [7:0] S_AXI_ARADDR_I,
   input wire logic S_AXI_ARVALID_I,
   output logic S_AXI_ARREADY_O,
   output logic [31:0] S_AXI_RDATA_O,
   output logic [1:0] S_AXI_RRESP_O,
   output logic S_AXI_RVALID_O,
   input wire logic S_AXI_RREADY_I,
   // UART datapath side
   input wire logic RX_PUSH_I,
   input wire logic [8:0] RX_DATA_I,
   input wire logic TX_OVERFLOW_I,
   input wire logic TX_EMPTY_I,
   input wire logic BREAK_DET_I,
   input wire logic FRAME_ERR_I,
   input wire logic PARITY_ERR_I,
   input wire logic CTS_I,
   input wire logic LIN_BREAK_I,
   output logic RX_POP_O,
   output logic IRQ_O
);
   // ----------------------------------------------------------------
   // Declarations
   // ----------------------------------------------------------------
   logic aw_held_reg, w_held_reg;
   logic [7:0] waddr_reg;
   logic [31:0] wdata_reg;
   logic [3:0] wstrb_reg;
   logic [31:0] wmask;
   logic wr_go, rd_go, wr_hit, rd_hit;
   logic [31:0] rd_value;
   logic [8:0] enable_reg;
   logic [7:0] tout_cmp_reg;
   logic [2:0] ctrl_reg;
   logic [NUM_EVT-1:0] evt_mask_reg, evt_status_reg, evt_now;
   logic [NUM_EVT-1:0] evt_prev_reg;
   logic rx_over_reg, tx_over_reg, addr_flag_reg;
   logic parity_reg, frame_reg, break_reg;
   logic cts_prev_reg, cts_chg_reg, lin_flag_reg;
   logic tout_flag_reg, thre_reg;
   logic [6:0] rx_count_reg;
   logic [7:0] idle_cnt_reg;
   logic rx_pop, rx_nonempty, overflow_any, line_any;
   logic [7:0] flags;
   logic [7:0] inds;
   logic [3:0] dma_flags, dma_inds;
   logic [31:0] isr_value;
   logic w1c_line, w1c_modem, w1c_isr;

   // ----------------------------------------------------------------
   // Write channel: address and data taken in either order
   // ----------------------------------------------------------------
   always_ff @(posedge MCLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         aw_held_reg <= 1'b0;
         waddr_reg <= 8'h00;
      end else if (S_AXI_AWVALID_I && S_AXI_AWREADY_O) begin
         aw_held_reg <= 1'b1;
         waddr_reg <= S_AXI_AWADDR_I;
      end else if (wr_go) begin
         aw_held_reg <= 1'b0;
      end
   end

   always_ff @(posedge MCLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         w_held_reg <= 1'b0;
         wdata_reg <= 32'h0000_0000;
         wstrb_reg <= 4'h0;
      end else if (S_AXI_WVALID_I && S_AXI_WREADY_O) begin
         w_held_reg <= 1'b1;
         wdata_reg <= S_AXI_WDATA_I;
         wstrb_reg <= S_AXI_WSTRB_I;
      end else if (wr_go) begin
         w_held_reg <= 1'b0;
      end
   end

   // Ready drops once a beat is held, so a second write waits
   always_ff @(posedge MCLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         S_AXI_AWREADY_O <= 1'b0;
         S_AXI_WREADY_O <= 1'b0;
      end else begin
         S_AXI_AWREADY_O <= !aw_held_reg && !S_AXI_AWREADY_O
            && !S_AXI_BVALID_O;
         S_AXI_WREADY_O <= !w_held_reg && !S_AXI_WREADY_O
            && !S_AXI_BVALID_O;
      end
   end

   assign wr_go = aw_held_reg && w_held_reg && !S_AXI_BVALID_O;
   assign wmask = {{8{wstrb_reg[3]}}, {8{wstrb_reg[2]}},
                   {8{wstrb_reg[1]}}, {8{wstrb_reg[0]}}};

   // Write address decode; unmapped gets SLVERR
   always_comb begin
      unique case (waddr_reg)
         OFS_RECEIVE_BUF, OFS_ENABLE, OFS_MODEM, OFS_LINE, OFS_ISR,
         OFS_TIMEOUT, OFS_CTRL, OFS_EVT_STATUS, OFS_EVT_MASK:
            wr_hit = 1'b1;
         default:
            wr_hit = 1'b0;
      endcase
   end

   always_ff @(posedge MCLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         S_AXI_BVALID_O <= 1'b0;
         S_AXI_BRESP_O <= RESP_OKAY;
      end else if (wr_go) begin
         S_AXI_BVALID_O <= 1'b1;
         S_AXI_BRESP_O <= wr_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (S_AXI_BREADY_I) begin
         S_AXI_BVALID_O <= 1'b0;
      end
   end

   // Write-one-to-clear strobes, masked by byte lanes
   assign w1c_line = wr_go && (waddr_reg == OFS_LINE);
   assign w1c_modem = wr_go && (waddr_reg == OFS_MODEM);
   assign w1c_isr = wr_go && (waddr_reg == OFS_ISR);

   // ----------------------------------------------------------------
   // Software-written control registers
   // ----------------------------------------------------------------
   always_ff @(posedge MCLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         enable_reg <= ENABLE_RESET;
         tout_cmp_reg <= TOUT_CMP_RESET;
         ctrl_reg <= CTRL_RESET;
         evt_mask_reg <= '0;
      end else if (wr_go) begin
         if (waddr_reg == OFS_ENABLE) begin
            enable_reg <= (enable_reg & ~wmask[8:0])
               | (wdata_reg[8:0] & wmask[8:0]);
         end
         if (waddr_reg == OFS_TIMEOUT && wstrb_reg[0]) begin
            tout_cmp_reg <= wdata_reg[7:0];
         end
         if (waddr_reg == OFS_CTRL && wstrb_reg[0]) begin
            ctrl_reg <= wdata_reg[2:0];
         end
         if (waddr_reg == OFS_EVT_MASK && wstrb_reg[0]) begin
            evt_mask_reg <= wdata_reg[NUM_EVT-1:0];
         end
      end
   end

   // ----------------------------------------------------------------
   // Read channel: one cycle from address to data
   // ----------------------------------------------------------------
   assign rd_go = S_AXI_ARVALID_I && S_AXI_ARREADY_O;

   always_ff @(posedge MCLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         S_AXI_ARREADY_O <= 1'b0;
      end else begin
         S_AXI_ARREADY_O <= !S_AXI_ARREADY_O && !S_AXI_RVALID_O
            && !rd_go;
      end
   end

   // Read mux; reserved bits and unmapped offsets return zero
   always_comb begin
      rd_hit = 1'b1;
      rd_value = 32'h0000_0000;
      unique case (S_AXI_ARADDR_I)
         OFS_RECEIVE_BUF: rd_value[8:0] = RX_DATA_I;
         OFS_ENABLE: rd_value[8:0] = enable_reg;
         OFS_MODEM: begin
            rd_value[MD_CTS_CHG] = cts_chg_reg;
            rd_value[MD_CTS_LVL] = cts_prev_reg;
         end
         OFS_LINE: begin
            rd_value[LN_RX_OVF] = rx_over_reg;
            rd_value[LN_ADDR] = addr_flag_reg;
            rd_value[LN_PARITY] = parity_reg;
            rd_value[LN_FRAME] = frame_reg;
            rd_value[LN_BREAK] = break_reg;
            rd_value[LN_TX_OVF] = tx_over_reg;
         end
         OFS_ISR: rd_value = isr_value;
         OFS_TIMEOUT: rd_value[7:0] = tout_cmp_reg;
         OFS_CTRL: rd_value[2:0] = ctrl_reg;
         OFS_EVT_STATUS: rd_value[NUM_EVT-1:0] = evt_status_reg;
         OFS_EVT_MASK: rd_value[NUM_EVT-1:0] = evt_mask_reg;
         default: rd_hit = 1'b0;
      endcase
   end

   always_ff @(posedge MCLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         S_AXI_RVALID_O <= 1'b0;
         S_AXI_RDATA_O <= 32'h0000_0000;
         S_AXI_RRESP_O <= RESP_OKAY;
      end else if (rd_go) begin
         S_AXI_RVALID_O <= 1'b1;
         S_AXI_RDATA_O <= rd_value;
         S_AXI_RRESP_O <= rd_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (S_AXI_RREADY_I) begin
         S_AXI_RVALID_O <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // Receive FIFO occupancy and idle timeout
   // ----------------------------------------------------------------
   // A buffer read pops one byte; empty reads pop nothing
   assign rx_pop = rd_go && (S_AXI_ARADDR_I == OFS_RECEIVE_BUF)
      && rx_nonempty;
   assign rx_nonempty = (rx_count_reg != 7'h00);

   always_ff @(posedge MCLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         RX_POP_O <= 1'b0;
      end else begin
         RX_POP_O <= rx_pop;
      end
   end

   // A push into a full FIFO is lost and counts as overflow
   always_ff @(posedge MCLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         rx_count_reg <= 7'h00;
      end else if (RX_PUSH_I && !rx_pop
                   && rx_count_reg != RX_FIFO_DEPTH) begin
         rx_count_reg <= rx_count_reg + 7'h01;
      end else if (rx_pop && !RX_PUSH_I) begin
         rx_count_reg <= rx_count_reg - 7'h01;
      end
   end

   // Idle counter restarts on any FIFO activity
   always_ff @(posedge MCLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         idle_cnt_reg <= 8'h00;
      end else if (RX_PUSH_I || rx_pop || !rx_nonempty) begin
         idle_cnt_reg <= 8'h00;
      end else if (idle_cnt_reg != tout_cmp_reg) begin
         idle_cnt_reg <= idle_cnt_reg + 8'h01;
      end
   end

   // Timeout flag: a clearing read of a non-empty FIFO pops, which blocks the set, so the read wins
   always_ff @(posedge MCLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         tout_flag_reg <= 1'b0;
      end else if (rx_nonempty && !RX_PUSH_I && !rx_pop
                   && idle_cnt_reg == tout_cmp_reg) begin
         tout_flag_reg <= 1'b1;
      end else if (rd_go && S_AXI_ARADDR_I == OFS_RECEIVE_BUF
                   && ctrl_reg[CT_RX_EN]) begin
         tout_flag_reg <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // Line status flags, write one to clear, set wins
   // ----------------------------------------------------------------
   always_ff @(posedge MCLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         rx_over_reg <= 1'b0;
         tx_over_reg <= 1'b0;
      end else begin
         if (RX_PUSH_I && !rx_pop && rx_count_reg == RX_FIFO_DEPTH) begin
            rx_over_reg <= 1'b1;
         end else if (w1c_line && wmask[LN_RX_OVF]
                      && wdata_reg[LN_RX_OVF]) begin
            rx_over_reg <= 1'b0;
         end
         if (TX_OVERFLOW_I) begin
            tx_over_reg <= 1'b1;
         end else if (w1c_line && wmask[LN_TX_OVF]
                      && wdata_reg[LN_TX_OVF]) begin
            tx_over_reg <= 1'b0;
         end
      end
   end

   // Error flags from the receiver; address flag only in RS-485 mode
   always_ff @(posedge MCLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         parity_reg <= 1'b0;
         frame_reg <= 1'b0;
         break_reg <= 1'b0;
         addr_flag_reg <= 1'b0;
      end else begin
         parity_reg <= PARITY_ERR_I || (parity_reg && !(w1c_line
            && wmask[LN_PARITY] && wdata_reg[LN_PARITY]));
         frame_reg <= FRAME_ERR_I || (frame_reg && !(w1c_line
            && wmask[LN_FRAME] && wdata_reg[LN_FRAME]));
         break_reg <= BREAK_DET_I || (break_reg && !(w1c_line
            && wmask[LN_BREAK] && wdata_reg[LN_BREAK]));
         addr_flag_reg <= (RX_PUSH_I && RX_DATA_I[8]
            && ctrl_reg[CT_RS485])
            || (addr_flag_reg && !(w1c_line && wmask[LN_ADDR]
            && wdata_reg[LN_ADDR]));
      end
   end

   // ----------------------------------------------------------------
   // CTS change, LIN break and transmit empty
   // ----------------------------------------------------------------
   always_ff @(posedge MCLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         cts_prev_reg <= 1'b0;
         cts_chg_reg <= 1'b0;
         lin_flag_reg <= 1'b0;
         thre_reg <= 1'b1;
      end else begin
         cts_prev_reg <= CTS_I;
         // Clearing the change flag also clears the DMA copy
         cts_chg_reg <= (CTS_I != cts_prev_reg)
            || (cts_chg_reg && !(w1c_modem && wmask[MD_CTS_CHG]
            && wdata_reg[MD_CTS_CHG]));
         lin_flag_reg <= LIN_BREAK_I || (lin_flag_reg && !(w1c_isr
            && wmask[IS_LIN_FLAG] && wdata_reg[IS_LIN_FLAG]));
         thre_reg <= TX_EMPTY_I;
      end
   end

   // ----------------------------------------------------------------
   // Status register image
   // ----------------------------------------------------------------
   // Flags are levels over their sources, so they fall exactly
   // when every source has been cleared
   assign overflow_any = rx_over_reg || tx_over_reg;
   assign line_any = break_reg || frame_reg || parity_reg
      || addr_flag_reg;

   // DMA mode routes events to the upper flags instead of the lower
   assign dma_flags = ctrl_reg[CT_DMA] ?
      {overflow_any, tout_flag_reg, cts_chg_reg, line_any} : 4'h0;
   assign dma_inds = dma_flags & {enable_reg[EN_OVF],
      enable_reg[EN_TOUT],
      enable_reg[EN_CTS],
      enable_reg[EN_LINE]};

   assign flags = {lin_flag_reg, 1'b0,
      ctrl_reg[CT_DMA] ? 4'h0 : {overflow_any, tout_flag_reg,
      cts_chg_reg, line_any}, thre_reg, rx_nonempty};
   assign inds = flags & {enable_reg[EN_LIN], 1'b0,
      enable_reg[EN_OVF],
      enable_reg[EN_TOUT], enable_reg[EN_CTS], enable_reg[EN_LINE],
      enable_reg[EN_THRE], enable_reg[EN_RDA]};

   // Read-only and reserved bits are not stored, so writes miss them
   always_comb begin
      isr_value = 32'h0000_0000;
      isr_value[7:0] = flags;
      isr_value[15:8] = inds;
      isr_value[IS_DMA_FLAG +: 4] = dma_flags;
      isr_value[IS_DMA_IND +: 4] = dma_inds;
   end

   // ----------------------------------------------------------------
   // Interrupt: sticky event bits, cleared by reading them
   // ----------------------------------------------------------------
   assign evt_now = {inds[7], dma_inds[3] || inds[5],
      dma_inds[2] || inds[4], dma_inds[1] || inds[3],
      dma_inds[0] || inds[2]};

   // Rising indicators set bits; a new event beats the read clear
   always_ff @(posedge MCLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         evt_prev_reg <= '0;
         evt_status_reg <= '0;
      end else begin
         evt_prev_reg <= evt_now;
         if (rd_go && S_AXI_ARADDR_I == OFS_EVT_STATUS) begin
            evt_status_reg <= evt_now & ~evt_prev_reg;
         end else begin
            evt_status_reg <= evt_status_reg | (evt_now & ~evt_prev_reg);
         end
      end
   end

   always_ff @(posedge MCLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         IRQ_O <= 1'b0;
      end else begin
         IRQ_O <= |(evt_status_reg & evt_mask_reg);
      end
   end
endmodule
`default_nettype wire

// [verification/uart_line_model.sv]
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// Far-side serial line and FIFO events
// ----------------------------------------
module uart_line_model (
   input wire logic clk_i,
   input wire logic pop_i,
   output logic push_o,
   output logic [8:0] data_o,
   output logic [4:0] evt_o,
   output logic cts_o,
   output logic tx_empty_o
);
   logic [8:0] cur = 9'h000;
   logic [8:0] head = 9'h000;
   logic [8:0] fifo_q[$];
   // Idle line, CTS low to match the detector's reset state
   initial begin
      push_o = 1'b0;
      evt_o = 5'h00;
      cts_o = 1'b0;
      tx_empty_o = 1'b1;
   end
   // Incoming char while pushed, otherwise the FIFO head
   assign data_o = push_o ? cur : head;
   // FIFO mirror; a char into a full FIFO is lost, empty shows inverse
   always @(posedge clk_i) begin
      if (push_o && fifo_q.size() < 64) begin
         fifo_q.push_back(cur);
      end
      if (pop_i && fifo_q.size() > 0) begin
         void'(fifo_q.pop_front());
      end
      head <= (fifo_q.size() > 0) ? fifo_q[0] : ~cur;
   end
   // One received char
   task push(input logic [8:0] c);
      @(posedge clk_i);
      push_o <= 1'b1;
      cur <= c;
      @(posedge clk_i);
      push_o <= 1'b0;
   endtask
   // Event pulse: 0 break, 1 frame, 2 parity, 3 tx ovf, 4 lin
   task pulse(input int k);
      @(posedge clk_i);
      evt_o[k] <= 1'b1;
      @(posedge clk_i);
      evt_o <= 5'h00;
   endtask
   // Modem line change
   task toggle_cts();
      @(posedge clk_i);
      cts_o <= ~cts_o;
   endtask
endmodule
`default_nettype wire

// [verification/uart_isr_dma_flags_sva.sv]
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// Port checker
// ----------------------------------------
module uart_isr_chk
   import uart_isr_pkg::*;
(
   input wire logic MCLK_I,
   input wire logic RST_N_I,
   input wire logic [1:0] S_AXI_BRESP_O,
   input wire logic S_AXI_BVALID_O,
   input wire logic S_AXI_BREADY_I,
   input wire logic [7:0] S_AXI_ARADDR_I,
   input wire logic S_AXI_ARVALID_I,
   input wire logic S_AXI_ARREADY_O,
   input wire logic [31:0] S_AXI_RDATA_O,
   input wire logic [1:0] S_AXI_RRESP_O,
   input wire logic S_AXI_RVALID_O,
   input wire logic S_AXI_RREADY_I,
   input wire logic RX_POP_O,
   input wire logic IRQ_O
);
   logic ar_hs, isr_rd, buf_rd, bad_rd;
   // Read accepts by target; above the last register is unmapped
   assign ar_hs = S_AXI_ARVALID_I && S_AXI_ARREADY_O;
   assign isr_rd = ar_hs && S_AXI_ARADDR_I == OFS_ISR;
   assign buf_rd = ar_hs && S_AXI_ARADDR_I == OFS_RECEIVE_BUF;
   assign bad_rd = ar_hs && S_AXI_ARADDR_I > OFS_EVT_MASK;
   default clocking cb @(posedge MCLK_I);
   endclocking
   default disable iff (!RST_N_I);
   bresp_hold_a: assert property (S_AXI_BVALID_O && !S_AXI_BREADY_I
      |=> S_AXI_BVALID_O && $stable(S_AXI_BRESP_O))
      else $error("write response dropped");
   rdata_hold_a: assert property (S_AXI_RVALID_O && !S_AXI_RREADY_I
      |=> S_AXI_RVALID_O && $stable(S_AXI_RDATA_O))
      else $error("read data dropped");
   read_answer_a: assert property (ar_hs |=> S_AXI_RVALID_O)
      else $error("read answer late");
   pop_cause_a: assert property (RX_POP_O |-> $past(buf_rd))
      else $error("pop without buffer read");
   unmapped_rd_a: assert property (bad_rd
      |=> S_AXI_RRESP_O == RESP_SLVERR && S_AXI_RDATA_O == 32'h0)
      else $error("unmapped read answered");
   isr_reserved_a: assert property (isr_rd
      |=> (S_AXI_RDATA_O & 32'hc3c3_4040) == 32'h0)
      else $error("reserved bits nonzero");
   dma_ind_flag_a: assert property (isr_rd
      |=> (S_AXI_RDATA_O[29:26] & ~S_AXI_RDATA_O[21:18]) == 4'h0)
      else $error("indicator without flag");
   lin_ind_flag_a: assert property (isr_rd
      |=> !S_AXI_RDATA_O[15] || S_AXI_RDATA_O[7])
      else $error("lin indicator without flag");
   irq_seen_c: cover property ($rose(IRQ_O));
   pop_seen_c: cover property (RX_POP_O);
   slverr_c: cover property (S_AXI_BVALID_O && S_AXI_BRESP_O[1]);
endmodule
bind uart_isr_dma_flags uart_isr_chk u_chk (.MCLK_I, .RST_N_I,
   .S_AXI_BRESP_O, .S_AXI_BVALID_O, .S_AXI_BREADY_I, .S_AXI_ARADDR_I,
   .S_AXI_ARVALID_I, .S_AXI_ARREADY_O, .S_AXI_RDATA_O, .S_AXI_RRESP_O,
   .S_AXI_RVALID_O, .S_AXI_RREADY_I, .RX_POP_O, .IRQ_O);
`default_nettype wire

// [verification/uart_isr_dma_flags_tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// Bench top
// ----------------------------------------
module uart_isr_dma_flags_tb_top;
   import uart_isr_pkg::*;
   logic clk = 1'b0, rst_n = 1'b0, awv = 1'b0, wv = 1'b0;
   logic bready = 1'b0, arv = 1'b0, rready = 1'b0;
   logic [7:0] awaddr = 8'h00, araddr = 8'h00;
   logic [31:0] wdata = 32'h0, rd_d, rdata;
   logic awr, wr_r, bv, arr, rv, pop, irq, push, cts, tmt;
   logic [1:0] bresp, rresp, rsp;
   logic [8:0] rxd, ch, c0;
   logic [4:0] ev;
   int n_errors = 0, n_tests = 0, cyc = 0, seed = 32'hd83d;
   uart_isr_dma_flags u_dut (.MCLK_I(clk), .RST_N_I(rst_n),
      .S_AXI_AWADDR_I(awaddr), .S_AXI_AWVALID_I(awv),
      .S_AXI_AWREADY_O(awr), .S_AXI_WDATA_I(wdata),
      .S_AXI_WSTRB_I(4'hf), .S_AXI_WVALID_I(wv), .S_AXI_WREADY_O(wr_r),
      .S_AXI_BRESP_O(bresp), .S_AXI_BVALID_O(bv), .S_AXI_BREADY_I(bready),
      .S_AXI_ARADDR_I(araddr), .S_AXI_ARVALID_I(arv),
      .S_AXI_ARREADY_O(arr), .S_AXI_RDATA_O(rdata),
      .S_AXI_RRESP_O(rresp), .S_AXI_RVALID_O(rv), .S_AXI_RREADY_I(rready),
      .RX_PUSH_I(push), .RX_DATA_I(rxd), .TX_OVERFLOW_I(ev[3]),
      .TX_EMPTY_I(tmt), .BREAK_DET_I(ev[0]), .FRAME_ERR_I(ev[1]),
      .PARITY_ERR_I(ev[2]), .CTS_I(cts), .LIN_BREAK_I(ev[4]),
      .RX_POP_O(pop), .IRQ_O(irq));
   uart_line_model u_far (.clk_i(clk), .pop_i(pop), .push_o(push),
      .data_o(rxd),
      .evt_o(ev), .cts_o(cts), .tx_empty_o(tmt));
   // Free-running 10 MHz clock
   initial forever #50 clk = ~clk;
   task finish_test();
      $display("checks %0d mismatches %0d", n_tests, n_errors);
      if (n_errors == 0 && n_tests > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   task check(input string nm, input logic [31:0] s, e);
      n_tests++;
      if (s !== e) begin
         n_errors++;
         $display("MISMATCH %s exp %h seen %h", nm, e, s);
      end
   endtask
   // Late ready on purpose, so held read responses get exercised; bready rises with bv
   task wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      awaddr <= a;
      wdata <= d;
      awv <= 1'b1;
      wv <= 1'b1;
      fork
         begin do @(posedge clk); while (!awr); awv <= 1'b0; end
         begin do @(posedge clk); while (!wr_r); wv <= 1'b0; end
      join
      @(posedge clk);
      bready <= 1'b1;
      do @(posedge clk); while (!bv);
      rsp = bresp;
      bready <= 1'b0;
   endtask
   task rd(input logic [7:0] a);
      @(posedge clk);
      araddr <= a;
      arv <= 1'b1;
      do @(posedge clk); while (!arr);
      arv <= 1'b0;
      @(posedge clk);
      rready <= 1'b1;
      do @(posedge clk); while (!rv);
      rd_d = rdata;
      rsp = rresp;
      rready <= 1'b0;
   endtask
   // Upper half: indicators are flag AND enable, reserved zero
   function logic [15:0] exp_hi(input logic [3:0] f, en);
      return {2'b00, f & en, 4'h0, f, 2'b00};
   endfunction
   task chk_isr(input string nm, input logic [3:0] f, en);
      rd(OFS_ISR);
      check(nm, {16'h0, rd_d[31:16]}, {16'h0, exp_hi(f, en)});
   endtask
   // Hang guard, well above the expected run length
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         n_errors++;
         finish_test();
      end
   end
   // Main sequence
   initial begin
      repeat (20) @(posedge clk);
      rst_n <= 1'b1;
      rd(OFS_ISR);
      check("isr reset", rd_d, ISR_RESET);
      wr(OFS_ISR, 32'hffff_ffff);
      rd(OFS_ISR);
      check("isr ro", rd_d, ISR_RESET);
      rd(8'h3c);
      check("bad rd", {rd_d[31:2], rd_d[1:0] | rsp}, 32'h2);
      wr(8'h3c, 32'h1);
      check("bad wr", {30'h0, rsp}, 32'h2);
      wr(OFS_TIMEOUT, 32'hff);
      wr(OFS_CTRL, 32'h5);
      wr(OFS_ENABLE, 32'h13c);
      wr(OFS_EVT_MASK, 32'h1f);
      $display("test registers done");
      for (int k = 0; k < 3; k++) begin
         u_far.pulse(k);
         u_far.pulse((k + 1) % 3);
         chk_isr("line set", 4'h1, 4'hf);
         wr(OFS_LINE, 32'h40 >> k);
         chk_isr("line held", 4'h1, 4'hf);
         wr(OFS_LINE, 32'h40 >> ((k + 1) % 3));
         chk_isr("line clr", 4'h0, 4'hf);
      end
      wr(OFS_CTRL, 32'h7);
      u_far.push(9'h1a5);
      chk_isr("addr byte", 4'h1, 4'hf);
      wr(OFS_LINE, 32'h8);
      chk_isr("tout early", 4'h0, 4'hf);
      repeat (300) @(posedge clk);
      chk_isr("tout set", 4'h4, 4'hf);
      rd(OFS_RECEIVE_BUF);
      check("rx char", rd_d, 32'h1a5);
      chk_isr("tout clr", 4'h0, 4'hf);
      $display("test line and timeout done");
      u_far.toggle_cts();
      wr(OFS_ENABLE, 32'h134);
      chk_isr("cts off", 4'h2, 4'hd);
      wr(OFS_ENABLE, 32'h13c);
      chk_isr("cts ind", 4'h2, 4'hf);
      wr(OFS_MODEM, 32'h1);
      chk_isr("cts clr", 4'h0, 4'hf);
      wr(OFS_CTRL, 32'h5);
      u_far.pulse(3);
      chk_isr("tx ovf", 4'h8, 4'hf);
      for (int i = 0; i < 65; i++) begin
         ch = 9'($random(seed));
         if (i == 0) c0 = ch;
         u_far.push(ch);
      end
      wr(OFS_LINE, 32'h100_0000);
      chk_isr("rx ovf", 4'h8, 4'hf);
      wr(OFS_LINE, 32'h1);
      chk_isr("ovf clr", 4'h0, 4'hf);
      rd(OFS_RECEIVE_BUF);
      check("fifo head", rd_d, {23'h0, c0});
      $display("test modem and overflow done");
      u_far.pulse(4);
      rd(OFS_ISR);
      check("lin ind", {30'h0, rd_d[15], rd_d[7]}, 32'h3);
      wr(OFS_ISR, 32'h80);
      rd(OFS_ISR);
      check("lin clr", {30'h0, rd_d[15], rd_d[7]}, 32'h0);
      check("irq on", {31'h0, irq}, 32'h1);
      rd(OFS_EVT_STATUS);
      repeat (2) @(posedge clk);
      check("irq off", {31'h0, irq}, 32'h0);
      wr(OFS_EVT_MASK, 32'h0);
      u_far.toggle_cts();
      repeat (3) @(posedge clk);
      check("irq masked", {31'h0, irq}, 32'h0);
      rd(OFS_EVT_STATUS);
      check("cts event", rd_d & 32'h2, 32'h2);
      wr(OFS_CTRL, 32'h4);
      u_far.pulse(3);
      rd(OFS_ISR);
      check("ovf plain", {30'h0, rd_d[13], rd_d[5]}, 32'h3);
      check("no dma half", {16'h0, rd_d[31:16]}, 32'h0);
      $display("test lin and irq done");
      finish_test();
   end
endmodule
`default_nettype wire
